// ### hdl/reset_cause_map.svh
// Constants for the reset-cause and start-up time-out block.
// Assumes a 20 MHz system clock and an 8-bit plain register port.
`ifndef RESET_CAUSE_MAP_SVH
`define RESET_CAUSE_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RC_ADDR_STATUS 4'h0
`define RC_ADDR_FLAGS 4'h1
`define RC_ADDR_IRQ_STAT 4'h2
`define RC_ADDR_IRQ_MASK 4'h3
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define RC_BIT_BROWNOUT 0
`define RC_BIT_POWERON 1
`define RC_BIT_POWERDOWN 0
`define RC_BIT_TIMEOUT 1
`define RC_PC_RESET 13'h0000
`define RC_PC_VECTOR 13'h0004
`define RC_UPPER_PC_RESET 5'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define RC_CLK_HZ 20000000
`define RC_POWER_UP_DELAY_TIMER_MS 72
`define RC_POWER_UP_DELAY_TIMER_CYCLES ((`RC_CLK_HZ / 1000) * `RC_POWER_UP_DELAY_TIMER_MS)
`define RC_OST_PERIODS 1024
`endif

// ### hdl/reset_cause_pkg.sv
// Types shared by the reset-cause block.
// Assumes nothing of its surroundings.
package reset_cause_pkg;
  typedef enum logic [2:0] {
    EV_NONE,
    EV_POWER_ON,
    EV_BROWN_OUT,
    EV_MASTER_CLEAR_N_RUN,
    EV_MASTER_CLEAR_N_SLEEP,
    EV_WDT_RESET,
    EV_WDT_WAKE,
    EV_IRQ_WAKE
  } reset_event_e;
  typedef enum logic [0:0] {
    OSC_CRYSTAL,
    OSC_RC
  } osc_mode_e;
  typedef logic [7:0] reg_data_t;
endpackage

// ### hdl/reset_cause.sv
// Reset-cause flags, start-up time-out sequencing and start address choice.
// Assumes events arrive as one-cycle pulses from logic on clk_sys_i, while the
// supply-good level and oscillator tick come from outside and are synchronised.
//
// What this block does
// - Brown-out flag bit 0, cleared by brown-out
// - Brown-out flag undefined after power-on, software sets
// - Brown-out flag meaningless while detector disabled
// - Power-on flag bit 1, cleared only by power-on
// - Reduced variant reads bit 0 as zero
// - Power-up and wake waits per oscillator mode
// - Brown-out applies full power-up wait
// - Power-on sets time-out and power-down flags
// - Master-clear while running keeps both flags
// - Sleep master-clear or interrupt wake: 1,0
// - Watchdog reset 0,1; watchdog wake 0,0
// - Resets load zero; wakes resume next instruction
// - Interrupt wake with enable loads vector
// - Wake-up raises source interrupt flag
// - Upper latch cleared on reset, kept on wake
// - Oscillator wait only crystal, power-on, brown-out or wake
// - Supply dip restarts the power-up wait
`timescale 1ns/1ns
`default_nettype none
`include "reset_cause_map.svh"
module reset_cause #(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `RC_POWER_UP_DELAY_TIMER_CYCLES,
  parameter int unsigned OST_PERIODS = `RC_OST_PERIODS,
  parameter bit HAS_BROWNOUT = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire reset_cause_pkg::reset_event_e event_i,
  input wire reset_cause_pkg::osc_mode_e osc_mode_i,
  input wire logic power_timer_enable_cfg_i,
  input wire logic brownout_enable_cfg_i,
  input wire logic global_irq_enable_i,
  input wire logic supply_good_i,
  input wire logic osc_tick_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic hold_reset_o,
  output logic pc_load_o,
  output logic [12:0] pc_value_o,
  output logic pc_resume_o,
  output logic [4:0] upper_pc_latch_o,
  output logic wake_irq_flag_o,
  output logic irq_o
);
  import reset_cause_pkg::*;

  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_POWER_UP_DELAY_TIMER,
    SEQ_OST
  } seq_e;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Supply and oscillator come from outside this clock; two flops for supply, three for the oscillator tick.
  logic supply_s1_reg, supply_s2_reg, osc_s1_reg, osc_s2_reg, osc_s3_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      supply_s1_reg <= 1'b0;
      supply_s2_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else if (ce_i) begin
      supply_s1_reg <= supply_good_i;
      supply_s2_reg <= supply_s1_reg;
      osc_s1_reg <= osc_tick_i;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end
  // The edge detector reads the second and third flops, never the first.
  wire osc_edge = osc_s2_reg & ~osc_s3_reg;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire ev_por = (event_i == EV_POWER_ON);
  wire ev_bor = (event_i == EV_BROWN_OUT) && HAS_BROWNOUT;
  wire ev_master_clear_n_run = (event_i == EV_MASTER_CLEAR_N_RUN);
  wire ev_master_clear_n_slp = (event_i == EV_MASTER_CLEAR_N_SLEEP);
  wire ev_wdt_rst = (event_i == EV_WDT_RESET);
  wire ev_wdt_wake = (event_i == EV_WDT_WAKE);
  wire ev_irq_wake = (event_i == EV_IRQ_WAKE);
  wire ev_reset = ev_por | ev_bor | ev_master_clear_n_run | ev_master_clear_n_slp | ev_wdt_rst;
  wire ev_wake = ev_wdt_wake | ev_irq_wake;
  wire crystal = (osc_mode_i == OSC_CRYSTAL);
  // A brown-out dip while the power-up wait runs re-arms the wait.
  wire dip = brownout_enable_cfg_i && HAS_BROWNOUT && !supply_s2_reg;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire wr_status = wr_i && (addr_i == `RC_ADDR_STATUS);
  wire wr_mask = wr_i && (addr_i == `RC_ADDR_IRQ_MASK);
  wire rd_istat = rd_i && (addr_i == `RC_ADDR_IRQ_STAT);

  // ----------------------------------------
  // Power status flags
  // ----------------------------------------
  // Hardware clears win over a same-cycle software write of one.
  logic poweron_flag_n_reg, brownout_flag_n_reg;
  logic poweron_next, brownout_next;
  always_comb begin
    poweron_next = poweron_flag_n_reg;
    brownout_next = brownout_flag_n_reg;
    if (wr_status) begin
      poweron_next = wdata_i[`RC_BIT_POWERON];
      brownout_next = wdata_i[`RC_BIT_BROWNOUT];
    end
    if (ev_por) begin
      poweron_next = 1'b0;
    end
    if (ev_bor) begin
      brownout_next = 1'b0;
    end
    if (!HAS_BROWNOUT) begin
      brownout_next = 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      poweron_flag_n_reg <= 1'b0;
      brownout_flag_n_reg <= 1'b0;
    end else if (ce_i) begin
      poweron_flag_n_reg <= poweron_next;
      brownout_flag_n_reg <= brownout_next;
    end
  end

  // ----------------------------------------
  // Time-out and power-down flags
  // ----------------------------------------
  logic timeout_flag_n_reg, powerdown_flag_n_reg;
  logic timeout_next, powerdown_next;
  always_comb begin
    timeout_next = timeout_flag_n_reg;
    powerdown_next = powerdown_flag_n_reg;
    if (ev_por || ev_bor) begin
      timeout_next = 1'b1;
      powerdown_next = 1'b1;
    end else if (ev_master_clear_n_slp || ev_irq_wake) begin
      timeout_next = 1'b1;
      powerdown_next = 1'b0;
    end else if (ev_wdt_rst) begin
      timeout_next = 1'b0;
      powerdown_next = 1'b1;
    end else if (ev_wdt_wake) begin
      timeout_next = 1'b0;
      powerdown_next = 1'b0;
    end
    // A run-time master-clear leaves both flags as they are.
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      timeout_flag_n_reg <= 1'b1;
      powerdown_flag_n_reg <= 1'b1;
    end else if (ce_i) begin
      timeout_flag_n_reg <= timeout_next;
      powerdown_flag_n_reg <= powerdown_next;
    end
  end

  // ----------------------------------------
  // Start-up time-out sequencer
  // ----------------------------------------
  // The power timer runs on power-on and brown-out only; the enable is taken
  // as active high throughout, since the two tables disagree on polarity.
  wire use_power_up_delay_timer = (ev_por && power_timer_enable_cfg_i) || ev_bor;
  // Oscillator wait only for crystal modes on power-on, brown-out or wake.
  wire use_ost = crystal && (ev_por || ev_bor || ev_wake);
  seq_e seq_reg, seq_next;
  logic [31:0] cnt_reg, cnt_next;
  always_comb begin
    seq_next = seq_reg;
    cnt_next = cnt_reg;
    if (use_power_up_delay_timer) begin
      seq_next = SEQ_POWER_UP_DELAY_TIMER;
      cnt_next = 32'h00000000;
    end else if (use_ost) begin
      seq_next = SEQ_OST;
      cnt_next = 32'h00000000;
    end else if (ev_reset) begin
      seq_next = SEQ_RUN;
    end else begin
      unique case (seq_reg)
        SEQ_RUN: begin
          seq_next = SEQ_RUN;
        end
        SEQ_POWER_UP_DELAY_TIMER: begin
          if (dip) begin
            cnt_next = 32'h00000000;
          end else if (cnt_reg >= POWER_UP_DELAY_TIMER_CYCLES - 1) begin
            cnt_next = 32'h00000000;
            seq_next = crystal ? SEQ_OST : SEQ_RUN;
          end else begin
            cnt_next = cnt_reg + 32'h00000001;
          end
        end
        SEQ_OST: begin
          if (osc_edge) begin
            if (cnt_reg >= OST_PERIODS - 1) begin
              seq_next = SEQ_RUN;
              cnt_next = 32'h00000000;
            end else begin
              cnt_next = cnt_reg + 32'h00000001;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      seq_reg <= SEQ_RUN;
      cnt_reg <= 32'h00000000;
    end else if (ce_i) begin
      seq_reg <= seq_next;
      cnt_reg <= cnt_next;
    end
  end
  wire hold_next = (seq_next != SEQ_RUN);
  wire done_pulse = (seq_reg != SEQ_RUN) && (seq_next == SEQ_RUN);

  // ----------------------------------------
  // Program counter start point and upper latch
  // ----------------------------------------
  // Every reset restarts at zero; a wake resumes unless the vector applies.
  wire [12:0] pc_next = (ev_irq_wake && global_irq_enable_i) ? `RC_PC_VECTOR
                        : `RC_PC_RESET;
  wire pc_load_next = ev_reset | (ev_irq_wake && global_irq_enable_i);
  wire resume_next = ev_wdt_wake | (ev_irq_wake && !global_irq_enable_i);
  logic [4:0] upper_pc_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      upper_pc_reg <= `RC_UPPER_PC_RESET;
      pc_value_o <= `RC_PC_RESET;
      pc_load_o <= 1'b0;
      pc_resume_o <= 1'b0;
      wake_irq_flag_o <= 1'b0;
      hold_reset_o <= 1'b0;
    end else if (ce_i) begin
      if (ev_reset) begin
        upper_pc_reg <= `RC_UPPER_PC_RESET;
      end
      pc_value_o <= pc_next;
      pc_load_o <= pc_load_next;
      pc_resume_o <= resume_next;
      wake_irq_flag_o <= ev_wake;
      hold_reset_o <= hold_next;
    end
  end
  assign upper_pc_latch_o = upper_pc_reg;

  // ----------------------------------------
  // Event interrupts
  // ----------------------------------------
  // Bit 0 any reset, bit 1 any wake, bit 2 time-out done. Read clears,
  // but an event in the same cycle survives the clear.
  logic [2:0] istat_reg, imask_reg;
  wire [2:0] ev_vec = {done_pulse, ev_wake, ev_reset};
  wire [2:0] istat_next = (rd_istat ? 3'h0 : istat_reg) | ev_vec;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      istat_reg <= 3'h0;
      imask_reg <= 3'h0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      istat_reg <= istat_next;
      if (wr_mask) begin
        imask_reg <= wdata_i[2:0];
      end
      irq_o <= |(istat_next & (wr_mask ? wdata_i[2:0] : imask_reg));
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Brown-out bit is reported raw; with the detector off it means nothing.
  wire bor_rd = HAS_BROWNOUT ? brownout_flag_n_reg : 1'b0;
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (addr_i)
      `RC_ADDR_STATUS: rd_mux = {6'h00, poweron_flag_n_reg, bor_rd};
      `RC_ADDR_FLAGS: rd_mux = {6'h00, timeout_flag_n_reg, powerdown_flag_n_reg};
      `RC_ADDR_IRQ_STAT: rd_mux = {5'h00, istat_reg};
      `RC_ADDR_IRQ_MASK: rd_mux = {5'h00, imask_reg};
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_POR_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_por |=> !poweron_flag_n_reg)
    else $error("power-on flag not cleared");
  AST_BOR_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_bor |=> !brownout_flag_n_reg && $stable(poweron_flag_n_reg))
    else $error("brown-out flag wrong");
  AST_POR_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_por |=> timeout_flag_n_reg && powerdown_flag_n_reg)
    else $error("power-on flags wrong");
  AST_MASTER_CLEAR_N_KEEP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_master_clear_n_run |=> $stable(timeout_flag_n_reg) && $stable(powerdown_flag_n_reg))
    else $error("run master-clear changed flags");
  AST_SLEEP_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && (ev_master_clear_n_slp || ev_irq_wake) |=> timeout_flag_n_reg && !powerdown_flag_n_reg)
    else $error("sleep flags wrong");
  AST_WDT_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_wdt_wake |=> !timeout_flag_n_reg && !powerdown_flag_n_reg)
    else $error("watchdog wake flags wrong");
  AST_VECTOR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_irq_wake && global_irq_enable_i |=> pc_load_o && pc_value_o == 13'h0004)
    else $error("vector not loaded");
  AST_RESET_PC: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_reset |=> pc_load_o && pc_value_o == 13'h0000 && upper_pc_latch_o == 5'h00)
    else $error("reset start point wrong");
  AST_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_por && power_timer_enable_cfg_i |=> hold_reset_o [*8])
    else $error("power-up wait missing");
  AST_RC_NOWAIT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ce_i && ev_master_clear_n_run && seq_reg == SEQ_RUN |=> !hold_reset_o)
    else $error("unexpected wait");
endmodule
`default_nettype wire

// ### verif/reset_cause_bench.sv
// Self-checking bench for the reset-cause block and its reduced twin.
// Assumes the package and the design under hdl/ are compiled first.
`timescale 1ns/1ns
`default_nettype none
module reset_cause_bench;
  import reset_cause_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int unsigned PW = 20;
  localparam int unsigned OP = 4;
  logic clk, rstn, ce, pte, boe, global_irq_enable, sup, osc, wr, rd, hold, pc_load, pc_resume, wake, irq;
  reset_event_e ev, e;
  osc_mode_e mode;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rdata_lite, got, got_l;
  logic [12:0] pc_value;
  logic [4:0] upc;
  logic [31:0] seed;
  logic [1:0] osc_div;
  logic [1:0] m_flags;
  logic m_por, m_bor;
  int err_count, samples_checked, lo, hi, n;

  // Full variant under test.
  reset_cause #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .OST_PERIODS(OP), .HAS_BROWNOUT(1'b1)) dut (
    .clk_sys_i(clk),
    .rstn_i(rstn),
    .ce_i(ce),
    .event_i(ev),
    .osc_mode_i(mode),
    .power_timer_enable_cfg_i(pte),
    .brownout_enable_cfg_i(boe),
    .global_irq_enable_i(global_irq_enable),
    .supply_good_i(sup),
    .osc_tick_i(osc),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata),
    .hold_reset_o(hold),
    .pc_load_o(pc_load),
    .pc_value_o(pc_value),
    .pc_resume_o(pc_resume),
    .upper_pc_latch_o(upc),
    .wake_irq_flag_o(wake),
    .irq_o(irq)
  );

  // Reduced variant; only its status read-back is compared.
  reset_cause #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .OST_PERIODS(OP), .HAS_BROWNOUT(1'b0)) dut_lite (
    .clk_sys_i(clk),
    .rstn_i(rstn),
    .ce_i(ce),
    .event_i(ev),
    .osc_mode_i(mode),
    .power_timer_enable_cfg_i(pte),
    .brownout_enable_cfg_i(boe),
    .global_irq_enable_i(global_irq_enable),
    .supply_good_i(sup),
    .osc_tick_i(osc),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .rdata_o(rdata_lite),
    .hold_reset_o(),
    .pc_load_o(),
    .pc_value_o(),
    .pc_resume_o(),
    .upper_pc_latch_o(),
    .wake_irq_flag_o(),
    .irq_o()
  );

  // ----------------------------------------
  // Clock and oscillator tick
  // ----------------------------------------
  // The clock runs at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The oscillator tick toggles every third clock, so its rising edges are six clocks apart.
  always @(posedge clk) begin
    if (!rstn) begin
      osc_div <= 2'h0;
      osc <= 1'b0;
    end else if (osc_div == 2'h2) begin
      osc_div <= 2'h0;
      osc <= ~osc;
    end else begin
      osc_div <= 2'(osc_div + 2'h1);
    end
  end

  // ----------------------------------------
  // Reference functions
  // ----------------------------------------
  // Repeatable random source.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // Time-out and power-down flags after an event, as {timeout_n, powerdown_n}.
  function automatic logic [1:0] exp_flags(input reset_event_e v, input logic [1:0] cur);
    logic [1:0] r;
    r = cur;
    case (v)
      EV_POWER_ON, EV_BROWN_OUT: r = 2'h3;
      EV_MASTER_CLEAR_N_SLEEP, EV_IRQ_WAKE: r = 2'h2;
      EV_WDT_RESET: r = 2'h1;
      EV_WDT_WAKE: r = 2'h0;
      default: r = cur;
    endcase
    return r;
  endfunction

  // Start point as {load, resume, address}.
  function automatic logic [14:0] exp_pc(input reset_event_e v, input logic g);
    logic is_rst;
    is_rst = v inside {EV_POWER_ON, EV_BROWN_OUT, EV_MASTER_CLEAR_N_RUN, EV_MASTER_CLEAR_N_SLEEP, EV_WDT_RESET};
    if (v == EV_IRQ_WAKE && g) begin
      return {2'h2, 13'h0004};
    end
    if (v == EV_WDT_WAKE || v == EV_IRQ_WAKE) begin
      return {2'h1, 13'h0000};
    end
    return {is_rst, 1'b0, 13'h0000};
  endfunction

  // Bounds of the reset hold in clock cycles; the oscillator part depends on tick phase.
  function automatic void exp_wait(input reset_event_e v, input osc_mode_e m, input logic p,
                                   output int l, output int h);
    int t;
    logic o;
    t = ((v == EV_POWER_ON && p) || v == EV_BROWN_OUT) ? int'(PW) : 0;
    o = (m == OSC_CRYSTAL) && (v inside {EV_POWER_ON, EV_BROWN_OUT, EV_WDT_WAKE, EV_IRQ_WAKE});
    l = t + (o ? (int'(OP) - 1) * 6 + 1 : 0);
    h = t + (o ? int'(OP) * 6 + 1 : 0);
  endfunction

  // ----------------------------------------
  // Compare tasks
  // ----------------------------------------
  task automatic check_reg(input string name, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic check_pin(input string name, input logic [12:0] exp, input logic [12:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic check_wait(input string name, input int l, input int h, input int seen);
    samples_checked++;
    if (seen < l || seen > h) begin
      err_count++;
      $display("FAIL %s expected %0d to %0d seen %0d", name, l, h, seen);
    end
  endtask

  // ----------------------------------------
  // Bus and event drivers
  // ----------------------------------------
  // A write is one strobe cycle; the gap cycle after it keeps strobes from touching.
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d, output logic [7:0] dl);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    dl = rdata_lite;
  endtask

  // One event pulse, the start-point checks, the model update and a count of hold cycles.
  task automatic fire(input reset_event_e v, output int cnt);
    logic [14:0] p;
    @(posedge clk);
    ev <= v;
    p = exp_pc(v, global_irq_enable);
    @(posedge clk);
    ev <= EV_NONE;
    @(negedge clk);
    check_pin("pc_load", 13'(p[14]), 13'(pc_load));
    check_pin("pc_resume", 13'(p[13]), 13'(pc_resume));
    check_pin("pc_value", p[12:0], pc_value);
    check_pin("wake_flag", 13'(v inside {EV_WDT_WAKE, EV_IRQ_WAKE}), 13'(wake));
    check_pin("upper_pc", 13'h0000, 13'(upc));
    m_flags = exp_flags(v, m_flags);
    if (v == EV_POWER_ON) begin
      m_por = 1'b0;
    end
    if (v == EV_BROWN_OUT) begin
      m_bor = 1'b0;
    end
    cnt = hold ? 1 : 0;
    repeat (120) begin
      @(negedge clk);
      if (hold) begin
        cnt++;
      end
    end
  endtask

  // A supply dip inside the brown-out wait restarts it only with the detector enabled.
  task automatic dip_test(input logic en);
    int c;
    boe <= en;
    mode <= OSC_RC;
    fork
      fire(EV_BROWN_OUT, c);
      begin
        repeat (6) @(posedge clk);
        sup <= 1'b0;
        repeat (6) @(posedge clk);
        sup <= 1'b1;
      end
    join
    if (en) begin
      check_wait("dip hold", int'(PW) + 5, int'(PW) + 16, c);
    end else begin
      check_wait("dip ignored hold", int'(PW), int'(PW), c);
    end
    boe <= 1'b1;
    $display("test dip %0d done", en);
  endtask

  // ----------------------------------------
  // Verdict and watchdog
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The tests need under 8000 cycles; this limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    err_count = 0;
    samples_checked = 0;
    seed = 32'h0000000A;
    m_flags = 2'h3;
    m_por = 1'b0;
    m_bor = 1'b0;
    rstn <= 1'b0;
    ce <= 1'b1;
    ev <= EV_NONE;
    mode <= OSC_RC;
    pte <= 1'b1;
    boe <= 1'b1;
    global_irq_enable <= 1'b0;
    sup <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 4'h0;
    wdata <= 8'h00;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    reg_read(4'h0, got, got_l);
    check_reg("reset status", 8'h00, got);
    reg_read(4'h1, got, got_l);
    check_reg("reset flags", 8'h03, got);
    fire(EV_POWER_ON, n);
    check_wait("power-on hold", int'(PW), int'(PW), n);
    reg_read(4'h0, got, got_l);
    check_reg("power-on status", 8'h00, got);
    reg_write(4'h0, 8'h03);
    m_por = 1'b1;
    m_bor = 1'b1;
    reg_read(4'h0, got, got_l);
    check_reg("written status", 8'h03, got);
    check_reg("lite written status", 8'h02, got_l);
    $display("test power-on done");
    reg_write(4'h3, 8'h01);
    reg_read(4'h2, got, got_l);
    check_reg("event status", 8'h05, got);
    fire(EV_MASTER_CLEAR_N_RUN, n);
    check_pin("irq raised", 13'h0001, 13'(irq));
    reg_read(4'h2, got, got_l);
    check_reg("event status master_clear_n", 8'h01, got);
    check_pin("irq after clear", 13'h0000, 13'(irq));
    reg_read(4'h2, got, got_l);
    check_reg("event status cleared", 8'h00, got);
    $display("test interrupt done");
    dip_test(1'b1);
    dip_test(1'b0);
    @(posedge clk);
    ce <= 1'b0;
    ev <= EV_WDT_RESET;
    @(posedge clk);
    ev <= EV_NONE;
    ce <= 1'b1;
    @(negedge clk);
    check_pin("frozen pc_load", 13'h0000, 13'(pc_load));
    reg_read(4'h1, got, got_l);
    check_reg("frozen flags", {6'h00, m_flags}, got);
    $display("test clock enable done");
    for (int i = 0; i < 24; i++) begin
      seed = xorshift(seed);
      mode <= osc_mode_e'(seed[0]);
      pte <= seed[1];
      global_irq_enable <= seed[2];
      e = reset_event_e'(seed[5:3]);
      if (e == EV_NONE) begin
        e = EV_MASTER_CLEAR_N_RUN;
      end
      if (!m_por) begin
        reg_write(4'h0, 8'h03);
        m_por = 1'b1;
        m_bor = 1'b1;
      end
      exp_wait(e, osc_mode_e'(seed[0]), seed[1], lo, hi);
      fire(e, n);
      check_wait("hold length", lo, hi, n);
      reg_read(4'h0, got, got_l);
      check_reg("status", {6'h00, m_por, m_bor}, got);
      check_reg("lite status", {6'h00, m_por, 1'b0}, got_l);
      reg_read(4'h1, got, got_l);
      check_reg("flags", {6'h00, m_flags}, got);
    end
    $display("test random events done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    m_flags = 2'h3;
    m_por = 1'b0;
    m_bor = 1'b0;
    reg_read(4'h0, got, got_l);
    check_reg("rereset status", 8'h00, got);
    reg_read(4'h1, got, got_l);
    check_reg("rereset flags", 8'h03, got);
    reg_read(4'h3, got, got_l);
    check_reg("rereset mask", 8'h00, got);
    check_pin("rereset irq", 13'h0000, 13'(irq));
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
